// *** hw/frm_defines.svh ***
`ifndef FRM_DEFINES_SVH
`define FRM_DEFINES_SVH
`define FRM_REG_STATUS  8'h00
`define FRM_REG_AE_OFF  8'h04
`define FRM_REG_AF_OFF  8'h08
`define FRM_REG_LEVEL   8'h0c
`define FRM_OFF_RST     32'h0000007f
`define FRM_FT_EDGES    2'h2
`define FRM_RESP_OKAY   2'h0
`define FRM_RESP_SLVERR 2'h2
`endif

// *** hw/frm_pkg.sv ***
package frm_pkg;
  typedef enum logic {FRM_RUN, FRM_REPLAY} frm_rd_state_e;
  typedef logic [1:0] frm_resp_t;
endpackage

// *** hw/frm_fifo_ctrl.sv ***
`timescale 1ns/1ps
`include "frm_defines.svh"
module frm_fifo_ctrl #(
  parameter int DW = 36,
  parameter int AW = 19
) (
  // System
  input  logic                clock,
  input  logic                sys_rst,
  // Write port pins
  input  logic                write_clk_strobe,
  input  logic                write_enable_n,
  input  logic [DW-1:0]       write_data_in,
  // Read port pins
  input  logic                read_clk_strobe,
  input  logic                read_enable_n,
  input  logic                read_port_select_n,
  input  logic                output_drive_n,
  output logic [DW-1:0]       read_data_out,
  output logic                read_data_oe,
  // Reset and mode pins
  input  logic                full_reset_n,
  input  logic                soft_reset_n,
  input  logic                fallthrough_serial_in,
  input  logic                write_port_async_sel,
  input  logic                read_port_async_sel,
  input  logic                flag_timing_select,
  input  logic                serial_prog_sel,
  // Retransmit
  input  logic                replay_anchor,
  input  logic                replay_n,
  // Serial offset load
  input  logic                serial_clock,
  input  logic                serial_enable_n,
  // Flags, two copies each
  output logic [1:0]          empty_n,
  output logic [1:0]          full_n,
  output logic [1:0]          almost_empty_n,
  output logic [1:0]          almost_full_flag,
  // AXI4-Lite slave
  input  logic [7:0]          s_axi_awaddr,
  input  logic                s_axi_awvalid,
  output logic                s_axi_awready,
  input  logic [31:0]         s_axi_wdata,
  input  logic [3:0]          s_axi_wstrb,
  input  logic                s_axi_wvalid,
  output logic                s_axi_wready,
  output frm_pkg::frm_resp_t  s_axi_bresp,
  output logic                s_axi_bvalid,
  input  logic                s_axi_bready,
  input  logic [7:0]          s_axi_araddr,
  input  logic                s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output frm_pkg::frm_resp_t  s_axi_rresp,
  output logic                s_axi_rvalid,
  input  logic                s_axi_rready
);
  import frm_pkg::*;

  localparam int NC = 17;
  logic [NC-1:0] c_raw, c_s1, c_s2;
  logic [DW-1:0] d_s1, d_s2;
  logic wclk_s, rclk_s, wr_en_n_s, rd_en_n_s, rd_sel_n_s, drive_n_s;
  logic full_rst_n_s, soft_rst_n_s, ftsi_s, wasync_s, rasync_s;
  logic ftim_s, sprog_s, anchor_s, replay_n_s, sclk_s, ser_en_n_s;
  logic wclk_d, rclk_d, sclk_d;
  logic wr_edge, rd_edge, s_edge;

  // Pin synchronisers
  assign c_raw = {write_clk_strobe, read_clk_strobe, write_enable_n, read_enable_n,
                  read_port_select_n, output_drive_n, full_reset_n, soft_reset_n,
                  fallthrough_serial_in, write_port_async_sel, read_port_async_sel,
                  flag_timing_select, serial_prog_sel, replay_anchor, replay_n,
                  serial_clock, serial_enable_n};
  assign {wclk_s, rclk_s, wr_en_n_s, rd_en_n_s, rd_sel_n_s, drive_n_s,
          full_rst_n_s, soft_rst_n_s, ftsi_s, wasync_s, rasync_s, ftim_s,
          sprog_s, anchor_s, replay_n_s, sclk_s, ser_en_n_s} = c_s2;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      c_s1   <= '0;
      c_s2   <= '0;
      d_s1   <= '0;
      d_s2   <= '0;
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      c_s1   <= c_raw;
      c_s2   <= c_s1;
      d_s1   <= write_data_in;
      d_s2   <= d_s1;
      wclk_d <= wclk_s;
      rclk_d <= rclk_s;
      sclk_d <= sclk_s;
    end
  end

  assign wr_edge = wclk_s & ~wclk_d;
  assign rd_edge = rclk_s & ~rclk_d;
  assign s_edge  = sclk_s & ~sclk_d;

  // Both device resets act without the clock
  logic dev_rst, cfg_rst;
  assign dev_rst = sys_rst | ~full_reset_n | ~soft_reset_n;
  assign cfg_rst = sys_rst | ~full_reset_n;

  // Configuration latched while full reset is held
  logic fallthrough_mode, wr_async, rd_async, flag_sync, ser_prog;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fallthrough_mode <= 1'b0;
      wr_async         <= 1'b0;
      rd_async         <= 1'b0;
      flag_sync        <= 1'b0;
      ser_prog         <= 1'b0;
    end else if (!full_rst_n_s) begin
      fallthrough_mode <= ftsi_s;
      wr_async         <= ~wasync_s;
      rd_async         <= ~rasync_s;
      flag_sync        <= ftim_s;
      ser_prog         <= sprog_s;
    end
  end

  // Storage and pointers
  logic [DW-1:0] mem [2**AW];
  logic [AW:0]   wptr, rptr, level, mark_ptr;
  logic [AW-1:0] mark_addr, out_addr;
  logic          mark_active, mem_empty, mem_full, mark_block, wr_go;

  assign level      = wptr - rptr;
  assign mem_empty  = (level == '0);
  assign mark_block = mark_active && (wptr[AW-1:0] == mark_addr) && !mem_empty;
  assign mem_full   = level[AW] | mark_block;
  assign mark_ptr   = {wptr[AW] ^ (mark_addr > wptr[AW-1:0]), mark_addr};
  // Enable is ignored on a strobe-driven port
  assign wr_go = wr_edge & (wr_async | ~wr_en_n_s) & ~mem_full;

  always_ff @(posedge clock) begin
    if (wr_go) begin
      mem[wptr[AW-1:0]] <= d_s2;
    end
  end

  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      wptr <= '0;
    end else if (wr_go) begin
      wptr <= wptr + 1'b1;
    end
  end

  // Read side
  frm_rd_state_e rd_state;
  logic [DW-1:0] data_q;
  logic          out_valid, rd_req, replay_now, do_load, rd_drive;
  logic [1:0]    ft_cnt;

  assign rd_req     = rd_async | (~rd_en_n_s & ~rd_sel_n_s);
  assign replay_now = mark_active & ~replay_n_s;

  always_comb begin
    do_load = 1'b0;
    if (rd_edge && !mem_empty) begin
      if (rd_state == FRM_REPLAY) begin
        do_load = replay_n_s & fallthrough_mode;
      end else if (!replay_now) begin
        if (fallthrough_mode && !out_valid) begin
          do_load = (ft_cnt == `FRM_FT_EDGES);
        end else begin
          do_load = rd_req;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      rptr      <= '0;
      data_q    <= '0;
      out_addr  <= '0;
      out_valid <= 1'b0;
      ft_cnt    <= '0;
      rd_state  <= FRM_RUN;
    end else if (do_load) begin
      data_q    <= mem[rptr[AW-1:0]];
      out_addr  <= rptr[AW-1:0];
      rptr      <= rptr + 1'b1;
      out_valid <= 1'b1;
      ft_cnt    <= '0;
      rd_state  <= FRM_RUN;
    end else if (rd_edge) begin
      unique case (rd_state)
        FRM_RUN: begin
          if (replay_now) begin
            rptr      <= mark_ptr;
            out_valid <= 1'b0;
            ft_cnt    <= '0;
            rd_state  <= FRM_REPLAY;
          end else if (fallthrough_mode && !out_valid) begin
            ft_cnt <= mem_empty ? 2'h0 : ft_cnt + 1'b1;
          end else if (fallthrough_mode && rd_req && mem_empty) begin
            out_valid <= 1'b0;
          end
        end
        FRM_REPLAY: begin
          if (replay_n_s) begin
            rd_state <= FRM_RUN;
          end else begin
            rptr <= mark_ptr;
          end
        end
      endcase
    end
  end

  // Mark held while the anchor stays high
  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      mark_active <= 1'b0;
      mark_addr   <= '0;
    end else if (rd_edge) begin
      mark_active <= anchor_s;
      // Mark taken on entry only, a held anchor keeps it
      if (anchor_s && !mark_active) begin
        mark_addr <= out_addr;
      end
    end
  end

  // Bus drive: reset leaves bus driven until first read edge
  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      rd_drive <= 1'b1;
    end else if (rd_edge) begin
      rd_drive <= ~rd_sel_n_s;
    end
  end
  assign read_data_out = data_q;
  assign read_data_oe  = ~drive_n_s & (rd_async | rd_drive);

  // Flags
  logic [AW-1:0] ae_off, af_off;
  logic          ef_q, ff_q, pae_q, paf_q, ef_shown, full_shown, pae_now, paf_now;
  logic [AW:0]   af_level;
  assign af_level = (AW+1)'(2**AW) - {1'b0, af_off};
  assign pae_now  = level <= {1'b0, ae_off};
  assign paf_now  = level >= af_level;

  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      ef_q  <= 1'b0;
      pae_q <= 1'b0;
    end else if (rd_edge) begin
      ef_q  <= ~mem_empty;
      pae_q <= ~pae_now;
    end
  end

  always_ff @(posedge clock or posedge dev_rst) begin
    if (dev_rst) begin
      ff_q  <= 1'b0;
      paf_q <= 1'b1;
    end else if (wr_edge) begin
      ff_q  <= mem_full;
      paf_q <= ~paf_now;
    end
  end

  assign ef_shown   = (rd_state == FRM_REPLAY) ? 1'b0 :
                      (rd_async ? ~mem_empty : ef_q);
  assign full_shown = wr_async ? mem_full : ff_q;
  assign empty_n          = {2{fallthrough_mode ? ~out_valid : ef_shown}};
  assign full_n           = {2{fallthrough_mode ? full_shown : ~full_shown}};
  assign almost_empty_n   = {2{flag_sync ? pae_q : ~pae_now}};
  assign almost_full_flag = {2{flag_sync ? paf_q : ~paf_now}};

  // AXI4-Lite slave
  logic        aw_got, w_got, wr_fire, rd_hit;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q, wmask, next_rdata;
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_got & w_got;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      wmask        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FRM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got    <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got    <= 1'b1;
        w_data_q <= s_axi_wdata;
        wmask    <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == `FRM_REG_AE_OFF || aw_addr_q == `FRM_REG_AF_OFF)
                        ? `FRM_RESP_OKAY : `FRM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Offsets survive soft reset, not full reset
  always_ff @(posedge clock or posedge cfg_rst) begin
    if (cfg_rst) begin
      ae_off <= AW'(`FRM_OFF_RST);
      af_off <= AW'(`FRM_OFF_RST);
    end else if (s_edge && ser_prog && !ser_en_n_s) begin
      {ae_off, af_off} <= {ae_off[AW-2:0], af_off, ftsi_s};
    end else if (wr_fire && aw_addr_q == `FRM_REG_AE_OFF) begin
      ae_off <= (ae_off & ~wmask[AW-1:0]) | (w_data_q[AW-1:0] & wmask[AW-1:0]);
    end else if (wr_fire && aw_addr_q == `FRM_REG_AF_OFF) begin
      af_off <= (af_off & ~wmask[AW-1:0]) | (w_data_q[AW-1:0] & wmask[AW-1:0]);
    end
  end

  always_comb begin
    next_rdata = '0;
    rd_hit     = 1'b1;
    unique case (s_axi_araddr)
      `FRM_REG_STATUS: next_rdata[11:0] = {out_valid, rd_state == FRM_REPLAY,
                                           mark_active, ser_prog, flag_sync, rd_async,
                                           wr_async, fallthrough_mode,
                                           almost_full_flag[0], almost_empty_n[0],
                                           full_n[0], empty_n[0]};
      `FRM_REG_AE_OFF: next_rdata[AW-1:0] = ae_off;
      `FRM_REG_AF_OFF: next_rdata[AW-1:0] = af_off;
      `FRM_REG_LEVEL:  next_rdata[AW:0] = level;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `FRM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? `FRM_RESP_OKAY : `FRM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  chk_reset_clear: assert property (@(posedge clock) disable iff (sys_rst)
    dev_rst |-> (wptr == '0 && rptr == '0 && data_q == '0 && almost_full_flag == 2'b11))
    else $error("reset did not clear pointers or output");
  chk_dup_flags: assert property (@(posedge clock) disable iff (sys_rst)
    empty_n[0] == empty_n[1] && full_n[0] == full_n[1] &&
    almost_empty_n[0] == almost_empty_n[1] && almost_full_flag[0] == almost_full_flag[1])
    else $error("duplicate flags differ");
  chk_write_step: assert property (@(posedge clock) disable iff (dev_rst)
    wr_go |=> wptr == $past(wptr) + 1'b1)
    else $error("write pointer did not advance");
  chk_mark_guard: assert property (@(posedge clock) disable iff (dev_rst)
    wr_go |-> !(mark_active && wptr[AW-1:0] == mark_addr && !mem_empty))
    else $error("write passed marked location");
  chk_replay_ptr: assert property (@(posedge clock) disable iff (dev_rst)
    rd_edge && rd_state == FRM_RUN && replay_now && !do_load
    |=> rptr[AW-1:0] == $past(mark_addr) && rd_state == FRM_REPLAY)
    else $error("replay did not rewind read pointer");
  chk_replay_flag: assert property (@(posedge clock) disable iff (dev_rst)
    rd_state == FRM_REPLAY |-> empty_n == (fallthrough_mode ? 2'b11 : 2'b00))
    else $error("flag wrong during replay");
  chk_hold_output: assert property (@(posedge clock) disable iff (dev_rst)
    rd_edge && !fallthrough_mode && !rd_async && rd_en_n_s && rd_state == FRM_RUN
    |=> $stable(data_q))
    else $error("output changed without read");
  chk_mode_hold: assert property (@(posedge clock) disable iff (sys_rst)
    full_rst_n_s && $past(full_rst_n_s) |-> $stable(fallthrough_mode) && $stable(flag_sync))
    else $error("mode changed outside full reset");
  chk_fall_through: assert property (@(posedge clock) disable iff (dev_rst)
    fallthrough_mode && rd_edge && !out_valid && !mem_empty && ft_cnt == 2'h2
    && rd_state == FRM_RUN && !replay_now |=> out_valid ##0 empty_n == 2'b00)
    else $error("first word did not fall through");
  cov_replay: cover property (@(posedge clock) disable iff (dev_rst)
    rd_state == FRM_REPLAY ##1 rd_state == FRM_RUN);
  cov_full: cover property (@(posedge clock) disable iff (dev_rst) mem_full);
  cov_fall_through: cover property (@(posedge clock) disable iff (dev_rst)
    fallthrough_mode && $rose(out_valid));
endmodule

// *** testbench/frm_link_partner.sv ***
`timescale 1ns/1ps
module frm_link_partner (
  // System
  input  wire logic        clock,
  // Latched port modes, low = strobe
  input  wire logic        write_port_async_sel,
  input  wire logic        read_port_async_sel,
  // Write side
  output logic             write_clk_strobe,
  output logic             write_enable_n,
  output logic [35:0]      write_data_in,
  // Read side
  output logic             read_clk_strobe,
  output logic             read_enable_n,
  output logic             read_port_select_n
);
  logic wr_busy;
  logic rd_hold_n;
  logic rd_sel_n = 1'b0;

  // Strobe ports keep their enables low
  assign write_enable_n     = write_port_async_sel & ~wr_busy;
  assign read_enable_n      = read_port_async_sel & rd_hold_n;
  assign read_port_select_n = rd_sel_n;

  task automatic set_select(input logic sel_n);
    rd_sel_n <= sel_n;
  endtask

  initial begin
    write_clk_strobe = 1'b0;
    read_clk_strobe  = 1'b0;
    write_data_in    = '0;
    wr_busy          = 1'b0;
    rd_hold_n        = 1'b1;
  end

  // One 225 ns pin period per word, pin still between words
  task automatic write_word(input logic [35:0] d);
    write_data_in <= d;
    wr_busy       <= 1'b1;
    repeat (4) @(posedge clock);
    write_clk_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    write_clk_strobe <= 1'b0;
    wr_busy          <= 1'b0;
    write_data_in    <= ~d;
    @(posedge clock);
  endtask

  task automatic read_edge(input logic ren_n);
    rd_hold_n <= ren_n;
    repeat (4) @(posedge clock);
    read_clk_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    read_clk_strobe <= 1'b0;
    rd_hold_n       <= 1'b1;
    @(posedge clock);
  endtask
endmodule

// *** testbench/fifo_reset_mode_retransmit_bench.sv ***
`timescale 1ns/1ps
`include "frm_defines.svh"
module fifo_reset_mode_retransmit_bench;
  import frm_pkg::*;
  localparam int AW = 8;
  typedef struct {logic ren_n; logic [35:0] exp;} frm_row_s;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        full_reset_n = 1'b1;
  logic        soft_reset_n = 1'b1;
  logic        output_drive_n = 1'b0;
  logic        fallthrough_serial_in = 1'b0;
  logic        write_port_async_sel = 1'b1;
  logic        read_port_async_sel = 1'b1;
  logic        flag_timing_select = 1'b0;
  logic        replay_anchor = 1'b0;
  logic        replay_n = 1'b1;
  logic        write_clk_strobe, write_enable_n, read_clk_strobe;
  logic        read_enable_n, read_port_select_n, read_data_oe;
  logic [35:0] write_data_in, read_data_out;
  logic [1:0]  empty_n, full_n, almost_empty_n, almost_full_flag;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        serial_prog_sel = 1'b0;
  logic        serial_clock = 1'b0;
  logic        serial_enable_n = 1'b1;
  logic [15:0] ser_word = 16'h1234;
  logic [31:0] s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  frm_resp_t   s_axi_bresp, s_axi_rresp, resp;
  int          bad_count = 0;
  int          checks = 0;
  logic [35:0] wd [4] = '{36'h0_0000_0001, 36'hf_ffff_fffe, 36'h8_0000_0000, 36'ha_5a5a_5a5a};
  frm_row_s    rows [6] = '{'{1'b0, 36'h0_0000_0001}, '{1'b1, 36'h0_0000_0001},
                            '{1'b0, 36'hf_ffff_fffe}, '{1'b0, 36'h8_0000_0000},
                            '{1'b1, 36'h8_0000_0000}, '{1'b0, 36'ha_5a5a_5a5a}};

  always #12.5 clock = ~clock;

  frm_fifo_ctrl #(.AW(AW)) dut (
    .clock, .sys_rst, .write_clk_strobe, .write_enable_n, .write_data_in,
    .read_clk_strobe, .read_enable_n, .read_port_select_n, .output_drive_n,
    .read_data_out, .read_data_oe, .full_reset_n, .soft_reset_n, .fallthrough_serial_in,
    .write_port_async_sel, .read_port_async_sel, .flag_timing_select,
    .serial_prog_sel, .replay_anchor, .replay_n, .serial_clock,
    .serial_enable_n, .empty_n, .full_n, .almost_empty_n, .almost_full_flag,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  frm_link_partner link (
    .clock, .write_port_async_sel, .read_port_async_sel, .write_clk_strobe,
    .write_enable_n, .write_data_in, .read_clk_strobe, .read_enable_n,
    .read_port_select_n);

  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bits(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        resp = s_axi_rresp;
        rd   = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Mode pins steady through the whole reset pulse
  task automatic full_reset(input logic ft, input logic wa, input logic ra);
    fallthrough_serial_in <= ft;
    write_port_async_sel  <= wa;
    read_port_async_sel   <= ra;
    flag_timing_select    <= ft;
    full_reset_n          <= 1'b0;
    repeat (5) @(posedge clock);
    check_bits({empty_n, full_n, almost_empty_n, almost_full_flag},
               {{2{ft}}, {2{~ft}}, 4'h3});
    check_word(read_data_out, '0);
    full_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    fallthrough_serial_in <= 1'b0;
  endtask

  // Serial offset bit, one 200 ns pin period, clock still between bits
  task automatic ser_bit(input logic b, input logic en_n);
    fallthrough_serial_in <= b;
    serial_enable_n       <= en_n;
    repeat (4) @(posedge clock);
    serial_clock <= 1'b1;
    repeat (4) @(posedge clock);
    serial_clock <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    full_reset(1'b0, 1'b1, 1'b1);
    foreach (wd[i]) link.write_word(wd[i]);
    repeat (2) link.read_edge(1'b1);
    foreach (rows[i]) begin
      link.read_edge(rows[i].ren_n);
      check_word(read_data_out, rows[i].exp);
    end
    link.read_edge(1'b1);
    check_bits(empty_n, 2'b00);
    axi_rd(`FRM_REG_STATUS);
    check_bits(rd[6:4], 3'h0);
    axi_rd(8'h40);
    check_bits({resp, rd}, {`FRM_RESP_SLVERR, 32'h0});
    axi_wr(`FRM_REG_STATUS, 32'hffff);
    check_bits(resp, `FRM_RESP_SLVERR);
    axi_wr(`FRM_REG_AE_OFF, 32'h15);
    axi_rd(`FRM_REG_AE_OFF);
    check_bits({resp, rd}, {`FRM_RESP_OKAY, 32'h15});
    s_axi_wstrb <= 4'he;
    axi_wr(`FRM_REG_AE_OFF, 32'hff);
    axi_rd(`FRM_REG_AE_OFF);
    check_bits(rd, 32'h15);
    s_axi_wstrb <= 4'hf;
    // Bus drive follows output_drive_n
    output_drive_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_bits(read_data_oe, 1'b0);
    output_drive_n <= 1'b0;
    repeat (4) @(posedge clock);
    check_bits(read_data_oe, 1'b1);
    link.set_select(1'b1);
    link.read_edge(1'b0);
    check_bits(read_data_oe, 1'b0);
    link.set_select(1'b0);
    link.read_edge(1'b1);
    check_bits(read_data_oe, 1'b1);
    // Mark and replay, standard mode
    full_reset(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 132; i++) link.write_word(36'h100 + 36'(i));
    repeat (2) link.read_edge(1'b1);
    repeat (2) link.read_edge(1'b0);
    replay_anchor <= 1'b1;
    link.read_edge(1'b1);
    repeat (2) link.read_edge(1'b0);
    check_word(read_data_out, 36'h103);
    replay_n <= 1'b0;
    repeat (2) begin
      link.read_edge(1'b1);
      check_bits(empty_n, 2'b00);
    end
    replay_n <= 1'b1;
    link.read_edge(1'b1);
    check_bits(empty_n, 2'b11);
    link.read_edge(1'b0);
    check_word(read_data_out, 36'h101);
    replay_anchor <= 1'b0;
    link.read_edge(1'b0);
    check_word(read_data_out, 36'h102);
    // Fall-through, then soft reset keeps mode and offsets
    full_reset(1'b1, 1'b1, 1'b1);
    link.write_word(36'h9_1234_5678);
    repeat (2) link.read_edge(1'b1);
    check_bits(empty_n, 2'b11);
    link.read_edge(1'b1);
    check_word(read_data_out, 36'h9_1234_5678);
    check_bits(empty_n, 2'b00);
    // Replay in fall-through, mark on the word now shown
    for (int i = 0; i < 130; i++) link.write_word(36'h200 + 36'(i));
    replay_anchor <= 1'b1;
    link.read_edge(1'b1);
    repeat (2) link.read_edge(1'b0);
    replay_n <= 1'b0;
    link.read_edge(1'b1);
    check_bits(empty_n, 2'b11);
    replay_n <= 1'b1;
    link.read_edge(1'b1);
    check_word(read_data_out, 36'h9_1234_5678);
    check_bits(empty_n, 2'b00);
    replay_anchor <= 1'b0;
    link.read_edge(1'b1);
    axi_wr(`FRM_REG_AF_OFF, 32'h21);
    soft_reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    check_word(read_data_out, '0);
    check_bits({empty_n, full_n, almost_empty_n, almost_full_flag}, 8'hc3);
    soft_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    axi_rd(`FRM_REG_STATUS);
    check_bits(rd[4], 1'b1);
    axi_rd(`FRM_REG_AF_OFF);
    check_bits(rd, 32'h21);
    // Serial offset load, last bit with shift disabled
    serial_prog_sel <= 1'b1;
    full_reset(1'b0, 1'b1, 1'b1);
    @(posedge clock);
    for (int i = 15; i >= 0; i--) ser_bit(ser_word[i], 1'b0);
    ser_bit(1'b1, 1'b1);
    axi_rd(`FRM_REG_STATUS);
    check_bits(rd[8], 1'b1);
    axi_rd(`FRM_REG_AE_OFF);
    check_bits(rd, 32'h12);
    axi_rd(`FRM_REG_AF_OFF);
    check_bits(rd, 32'h34);
    serial_prog_sel <= 1'b0;
    // Strobe ports, standard mode only
    full_reset(1'b0, 1'b0, 1'b0);
    axi_rd(`FRM_REG_STATUS);
    check_bits(rd[6:4], 3'h6);
    for (int i = 0; i <= 2**AW; i++) link.write_word(36'(i));
    check_bits(full_n, 2'b00);
    link.read_edge(1'b0);
    check_word(read_data_out, 36'h0);
    check_bits(full_n, 2'b11);
    axi_rd(`FRM_REG_LEVEL);
    check_bits(rd, 32'(2**AW - 1));
    for (int i = 1; i < 2**AW; i++) begin
      link.read_edge(1'b0);
      check_word(read_data_out, 36'(i));
    end
    check_bits(empty_n, 2'b00);
    final_report;
  end

  initial begin
    #1000000;
    bad_count++;
    final_report;
  end
endmodule
